// >>> verilog/smsp_pkg.sv
package smsp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [31:0] SMSP_STATUS_ADDR   = 32'hFFFF0A00;
  localparam logic [31:0] SMSP_RECEIVE_ADDR  = 32'hFFFF0A04;
  localparam logic [31:0] SMSP_TRANSMIT_ADDR = 32'hFFFF0A08;
  localparam logic [31:0] SMSP_DIVIDER_ADDR  = 32'hFFFF0A0C;
  localparam logic [31:0] SMSP_CONTROL_ADDR  = 32'hFFFF0A10;

  localparam logic [15:0] SMSP_CONTROL_RST = 16'h0000;
  localparam logic [7:0]  SMSP_DIVIDER_RST = 8'h1B;
  localparam logic [7:0]  SMSP_DATA_RST    = 8'h00;
  localparam logic [15:0] SMSP_CONTROL_WMASK = 16'h1FEF;

  // Control field positions
  localparam int SMSP_CTL_EN     = 0;
  localparam int SMSP_CTL_MASTER = 1;
  localparam int SMSP_CTL_CPHA   = 2;
  localparam int SMSP_CTL_CPOL   = 3;
  localparam int SMSP_CTL_LSB    = 5;
  localparam int SMSP_CTL_TXMODE = 6;
  localparam int SMSP_CTL_UNDER  = 7;
  localparam int SMSP_CTL_OVWR   = 8;
  localparam int SMSP_CTL_SSEN   = 9;
  localparam int SMSP_CTL_SOE    = 10;
  localparam int SMSP_CTL_LOOP   = 11;
  localparam int SMSP_CTL_CONT   = 12;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CORE_FREQ_KHZ = 1000000000 / CLK_PERIOD_PS;
  localparam int REF_FREQ_KHZ  = 20480;
  localparam logic [17:0] SMSP_PRE_STEP = 18'(REF_FREQ_KHZ);
  localparam logic [17:0] SMSP_PRE_WRAP = 18'(CORE_FREQ_KHZ);
  localparam logic [3:0]  SMSP_LAST_HALF  = 4'hF;
  localparam logic [3:0]  SMSP_STALL_LAST = 4'h1;

  // Synchroniser lanes
  localparam int SMSP_PIN_SCLK = 0;
  localparam int SMSP_PIN_MOSI = 1;
  localparam int SMSP_PIN_MISO = 2;
  localparam int SMSP_PIN_SSN  = 3;

  typedef enum logic [1:0] {
    SMSP_IDLE  = 2'b00,
    SMSP_SHIFT = 2'b01,
    SMSP_STALL = 2'b10
  } smsp_state_e;

endpackage

// >>> verilog/smsp_port.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module smsp_port
  import smsp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Serial clock pin
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  // Master-out data pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  // Master-in data pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  // Chip select pin, active low
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_n_oe
);

  // ************************************************************
  // State
  // ************************************************************
  smsp_state_e state_reg, state_next;
  logic [15:0] ctl_reg, ctl_next;
  logic [7:0]  div_reg, div_next;
  logic [7:0]  txd_reg, txd_next, last_reg, last_next;
  logic [7:0]  rxd_reg, rxd_next, tsh_reg, tsh_next, rsh_reg, rsh_next;
  logic        txf_reg, txf_next, sending_reg, sending_next;
  logic        rxf_reg, rxf_next, ovf_reg, ovf_next, rxirq_reg, rxirq_next;
  logic        udf_reg, udf_next, txirq_reg, txirq_next, kick_reg, kick_next;
  logic [3:0]  hcnt_reg, hcnt_next;
  logic [2:0]  scnt_reg, scnt_next;
  logic [17:0] acc_reg, acc_next;
  logic [7:0]  dcnt_reg, dcnt_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        sclk_o_reg, sclk_o_next, sclk_oe_reg, sclk_oe_next;
  logic        mosi_o_reg, mosi_o_next, mosi_oe_reg, mosi_oe_next;
  logic        miso_o_reg, miso_o_next, miso_oe_reg, miso_oe_next;
  logic        ss_o_reg, ss_o_next, ss_oe_reg, ss_oe_next;
  logic [3:0]  sy1_reg, sy2_reg, sy3_reg, pin_reg, pin_next;

  // Decoded strobes and control fields
  logic wr_tx, wr_ctl, wr_div, rd_rx;
  logic en, master, cpha, cpol, lsb, loop;
  logic half, ref_tick, ld, done, smp, shf, udf_evt, din;
  logic s_lead, s_trail, st0_now;
  logic [17:0] acc_sum;
  logic [7:0]  load_val, rx_word;

  assign wr_tx  = reg_wr && (reg_addr == SMSP_TRANSMIT_ADDR);
  assign wr_ctl = reg_wr && (reg_addr == SMSP_CONTROL_ADDR);
  assign wr_div = reg_wr && (reg_addr == SMSP_DIVIDER_ADDR);
  assign rd_rx  = reg_rd && (reg_addr == SMSP_RECEIVE_ADDR);
  assign en     = ctl_reg[SMSP_CTL_EN];
  assign master = ctl_reg[SMSP_CTL_MASTER];
  assign cpha   = ctl_reg[SMSP_CTL_CPHA];
  assign cpol   = ctl_reg[SMSP_CTL_CPOL];
  assign lsb    = ctl_reg[SMSP_CTL_LSB];
  assign loop   = ctl_reg[SMSP_CTL_LOOP];
  assign st0_now = txf_reg | sending_reg;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // A pin change counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      assign pin_next[g] = (sy2_reg[g] == sy3_reg[g]) ? sy2_reg[g] : pin_reg[g];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sy1_reg <= 4'hF;
      sy2_reg <= 4'hF;
      sy3_reg <= 4'hF;
      pin_reg <= 4'hF;
    end else begin
      sy1_reg <= {ss_n_i, miso_i, mosi_i, sclk_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      pin_reg <= pin_next;
    end
  end

  // Slave clock edges, leading means leaving the idle level
  assign s_lead  = (pin_next[SMSP_PIN_SCLK] != pin_reg[SMSP_PIN_SCLK]) && (pin_next[SMSP_PIN_SCLK] != cpol);
  assign s_trail = (pin_next[SMSP_PIN_SCLK] != pin_reg[SMSP_PIN_SCLK]) && (pin_next[SMSP_PIN_SCLK] == cpol);

  // Received bit, looped back from our own data output when asked
  assign din = master ? (loop ? mosi_o_reg : pin_reg[SMSP_PIN_MISO])
                      : (loop ? miso_o_reg : pin_reg[SMSP_PIN_MOSI]);
  assign rx_word = lsb ? {din, rsh_reg[7:1]} : {rsh_reg[6:0], din};

  // Byte to shift out; an empty transmit register resends or sends zero
  assign load_val = txf_reg ? txd_reg : (ctl_reg[SMSP_CTL_UNDER] ? last_reg : 8'h00);

  // ************************************************************
  // Bit-rate generator
  // ************************************************************
  // A fractional accumulator makes the 20.48MHz reference from the
  // core clock, so the rate is exact on average with a cycle of jitter
  assign acc_sum  = acc_reg + SMSP_PRE_STEP;
  assign ref_tick = acc_sum >= SMSP_PRE_WRAP;
  assign half     = (state_reg != SMSP_IDLE) && ref_tick && (dcnt_reg == div_reg);

  always_comb begin
    acc_next  = 18'h00000;
    dcnt_next = 8'h00;
    if (state_reg != SMSP_IDLE) begin
      acc_next  = ref_tick ? (acc_sum - SMSP_PRE_WRAP) : acc_sum;
      dcnt_next = dcnt_reg;
      if (ref_tick) begin
        dcnt_next = (dcnt_reg == div_reg) ? 8'h00 : (dcnt_reg + 8'h01);
      end
    end
  end

  // ************************************************************
  // Shift engine, registers and flags
  // ************************************************************
  always_comb begin
    state_next   = state_reg;
    ctl_next     = ctl_reg;
    div_next     = div_reg;
    txd_next     = txd_reg;
    last_next    = last_reg;
    rxd_next     = rxd_reg;
    tsh_next     = tsh_reg;
    rsh_next     = rsh_reg;
    txf_next     = txf_reg;
    sending_next = sending_reg;
    rxf_next     = rxf_reg;
    ovf_next     = ovf_reg;
    rxirq_next   = rxirq_reg;
    udf_next     = udf_reg;
    txirq_next   = txirq_reg;
    kick_next    = kick_reg;
    hcnt_next    = hcnt_reg;
    scnt_next    = scnt_reg;
    sclk_o_next  = sclk_o_reg;
    ld           = 1'b0;
    done         = 1'b0;
    smp          = 1'b0;
    shf          = 1'b0;
    udf_evt      = 1'b0;

    // Master sequencing
    case (state_reg)
      SMSP_IDLE: begin
        sclk_o_next = cpol;
        hcnt_next   = 4'h0;
        if (en && master && kick_reg) begin
          ld         = 1'b1;
          kick_next  = 1'b0;
          state_next = SMSP_SHIFT;
        end
      end
      SMSP_SHIFT: begin
        if (half) begin
          sclk_o_next = ~sclk_o_reg;
          hcnt_next   = hcnt_reg + 4'h1;
          // Phase 0 samples on leading edges, phase 1 on trailing ones
          smp = cpha ? hcnt_reg[0] : ~hcnt_reg[0];
          shf = cpha ? (~hcnt_reg[0] && (hcnt_reg != 4'h0))
                     : (hcnt_reg[0] && (hcnt_reg != SMSP_LAST_HALF));
          if (hcnt_reg == SMSP_LAST_HALF) begin
            done = 1'b1;
            if (ctl_reg[SMSP_CTL_CONT] && txf_reg) begin
              ld = 1'b1;
            end else if (ctl_reg[SMSP_CTL_CONT]) begin
              state_next = SMSP_IDLE;
            end else begin
              state_next = SMSP_STALL;
            end
          end
        end
      end
      SMSP_STALL: begin
        sclk_o_next = cpol;
        if (half) begin
          hcnt_next = hcnt_reg + 4'h1;
          if (hcnt_reg == SMSP_STALL_LAST) begin
            state_next = SMSP_IDLE;
            hcnt_next  = 4'h0;
          end
        end
      end
      default: begin
        state_next = SMSP_IDLE;
      end
    endcase
    if (!en || !master) begin
      state_next  = SMSP_IDLE;
      sclk_o_next = cpol;
    end

    // Slave sequencing, only while chip select is held low
    if (en && !master) begin
      if (pin_next[SMSP_PIN_SSN]) begin
        scnt_next = 3'h0;
      end else if (pin_reg[SMSP_PIN_SSN]) begin
        scnt_next = 3'h0;
        ld        = ~cpha;
      end else begin
        smp = cpha ? s_trail : s_lead;
        if (cpha ? s_lead : s_trail) begin
          // Phase 0 also reloads on the trailing edge after a byte
          ld  = (scnt_reg == 3'h0);
          shf = (scnt_reg != 3'h0);
        end
        if (smp) begin
          scnt_next = scnt_reg + 3'h1;
          done      = (scnt_reg == 3'h7);
        end
      end
    end

    // Shift registers
    if (smp) begin
      rsh_next = rx_word;
    end
    if (shf) begin
      tsh_next = lsb ? (tsh_reg >> 1) : (tsh_reg << 1);
    end

    // Byte finished: sender idle, receive register updated unless still full without overwrite; in phase 0 the
    // last half period samples nothing, so the shifter already holds the byte
    if (done) begin
      sending_next = 1'b0;
      if (rxf_reg && !rd_rx) begin
        ovf_next = 1'b1;
        if (ctl_reg[SMSP_CTL_OVWR]) begin
          rxd_next = smp ? rx_word : rsh_reg;
        end
      end else begin
        rxd_next = smp ? rx_word : rsh_reg;
        rxf_next = 1'b1;
      end
    end

    // Load the shifter from the transmit register
    if (ld) begin
      tsh_next = load_val;
      if (txf_reg) begin
        txf_next     = 1'b0;
        sending_next = 1'b1;
        last_next    = txd_reg;
      end else begin
        udf_evt = 1'b1;
      end
    end

    // Software side effects; they run after the engine so a
    // transmit write in the load cycle still keeps its new byte
    if (wr_ctl) begin
      ctl_next = reg_wdata & SMSP_CONTROL_WMASK;
      if (!reg_wdata[SMSP_CTL_EN] && (state_reg == SMSP_IDLE) && !st0_now) begin
        txirq_next = 1'b0;
      end
    end
    if (wr_div) begin
      div_next = reg_wdata[7:0];
    end
    if (wr_tx) begin
      txd_next   = reg_wdata[7:0];
      txf_next   = 1'b1;
      udf_next   = 1'b0;
      txirq_next = 1'b0;
      if (ctl_reg[SMSP_CTL_TXMODE]) begin
        kick_next = 1'b1;
      end
    end
    if (rd_rx) begin
      rxf_next   = 1'b0;
      ovf_next   = done && rxf_reg;
      rxirq_next = 1'b0;
      if (!ctl_reg[SMSP_CTL_TXMODE]) begin
        kick_next = 1'b1;
      end
    end

    // Hardware sets win over software clears
    if (udf_evt) begin
      udf_next = 1'b1;
    end
    if (done) begin
      rxirq_next = 1'b1;
    end
    if (udf_evt || (st0_now && !(txf_next | sending_next))) begin
      txirq_next = 1'b1;
    end
  end

  // ************************************************************
  // Pin drivers and read data
  // ************************************************************
  always_comb begin
    mosi_o_next  = lsb ? tsh_next[0] : tsh_next[7];
    miso_o_next  = mosi_o_next;
    sclk_oe_next = en && master;
    mosi_oe_next = en && master;
    ss_oe_next   = en && master && ctl_reg[SMSP_CTL_SSEN];
    ss_o_next    = (state_next != SMSP_SHIFT);
    miso_oe_next = en && !master && ctl_reg[SMSP_CTL_SOE] && !pin_next[SMSP_PIN_SSN];
    rdata_next   = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        SMSP_STATUS_ADDR:  rdata_next = {10'h000, ovf_reg, rxirq_reg, rxf_reg, udf_reg, txirq_reg, st0_now};
        SMSP_RECEIVE_ADDR: rdata_next = {8'h00, rxd_reg};
        SMSP_DIVIDER_ADDR: rdata_next = {8'h00, div_reg};
        SMSP_CONTROL_ADDR: rdata_next = ctl_reg;
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  // Registering every group; outputs leave straight from flip-flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg   <= SMSP_IDLE;
      ctl_reg     <= SMSP_CONTROL_RST;
      div_reg     <= SMSP_DIVIDER_RST;
      txd_reg     <= SMSP_DATA_RST;
      last_reg    <= SMSP_DATA_RST;
      rxd_reg     <= SMSP_DATA_RST;
      tsh_reg     <= SMSP_DATA_RST;
      rsh_reg     <= SMSP_DATA_RST;
      txf_reg     <= 1'b0;
      sending_reg <= 1'b0;
      rxf_reg     <= 1'b0;
      ovf_reg     <= 1'b0;
      rxirq_reg   <= 1'b0;
      udf_reg     <= 1'b0;
      txirq_reg   <= 1'b0;
      kick_reg    <= 1'b0;
      hcnt_reg    <= 4'h0;
      scnt_reg    <= 3'h0;
      acc_reg     <= 18'h00000;
      dcnt_reg    <= 8'h00;
      rdata_reg   <= 16'h0000;
      sclk_o_reg  <= 1'b0;
      sclk_oe_reg <= 1'b0;
      mosi_o_reg  <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_o_reg  <= 1'b0;
      miso_oe_reg <= 1'b0;
      ss_o_reg    <= 1'b1;
      ss_oe_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ctl_reg     <= ctl_next;
      div_reg     <= div_next;
      txd_reg     <= txd_next;
      last_reg    <= last_next;
      rxd_reg     <= rxd_next;
      tsh_reg     <= tsh_next;
      rsh_reg     <= rsh_next;
      txf_reg     <= txf_next;
      sending_reg <= sending_next;
      rxf_reg     <= rxf_next;
      ovf_reg     <= ovf_next;
      rxirq_reg   <= rxirq_next;
      udf_reg     <= udf_next;
      txirq_reg   <= txirq_next;
      kick_reg    <= kick_next;
      hcnt_reg    <= hcnt_next;
      scnt_reg    <= scnt_next;
      acc_reg     <= acc_next;
      dcnt_reg    <= dcnt_next;
      rdata_reg   <= rdata_next;
      sclk_o_reg  <= sclk_o_next;
      sclk_oe_reg <= sclk_oe_next;
      mosi_o_reg  <= mosi_o_next;
      mosi_oe_reg <= mosi_oe_next;
      miso_o_reg  <= miso_o_next;
      miso_oe_reg <= miso_oe_next;
      ss_o_reg    <= ss_o_next;
      ss_oe_reg   <= ss_oe_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sclk_o    = sclk_o_reg;
  assign sclk_oe   = sclk_oe_reg;
  assign mosi_o    = mosi_o_reg;
  assign mosi_oe   = mosi_oe_reg;
  assign miso_o    = miso_o_reg;
  assign miso_oe   = miso_oe_reg;
  assign ss_n_o    = ss_o_reg;
  assign ss_n_oe   = ss_oe_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_ss_held_in_byte;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == SMSP_SHIFT && ss_oe_reg) |-> !ss_o_reg;
  endproperty
  a_ss_held_in_byte: assert property (p_ss_held_in_byte) else $error("chip select high during a byte");

  property p_stall_ss_high;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == SMSP_STALL) |-> ss_o_reg;
  endproperty
  a_stall_ss_high: assert property (p_stall_ss_high) else $error("chip select low during stall");

  property p_loopback;
    @(posedge clock) disable iff (sys_rst)
      (smp && master && loop && !lsb) |=> (rsh_reg[0] == $past(mosi_o_reg));
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback bit not captured");

  property p_slave_out_gate;
    @(posedge clock) disable iff (sys_rst)
      miso_oe_reg |-> $past(ctl_reg[SMSP_CTL_SOE]);
  endproperty
  a_slave_out_gate: assert property (p_slave_out_gate) else $error("slave output driven while disabled");

  property p_rx_read_clears;
    @(posedge clock) disable iff (sys_rst)
      (rd_rx && !done) |=> (!rxf_reg && !ovf_reg && !rxirq_reg);
  endproperty
  a_rx_read_clears: assert property (p_rx_read_clears) else $error("receive read left flags set");

  property p_tx_write_busy;
    @(posedge clock) disable iff (sys_rst)
      wr_tx |=> (txf_reg && !txirq_reg);
  endproperty
  a_tx_write_busy: assert property (p_tx_write_busy) else $error("transmit write not flagged");

  property p_udf_cleared;
    @(posedge clock) disable iff (sys_rst)
      (wr_tx && !udf_evt) |=> !udf_reg;
  endproperty
  a_udf_cleared: assert property (p_udf_cleared) else $error("underflow not cleared by write");

  property p_overflow_discard;
    @(posedge clock) disable iff (sys_rst)
      (done && rxf_reg && !rd_rx && !ctl_reg[SMSP_CTL_OVWR]) |=> ($stable(rxd_reg) && ovf_reg);
  endproperty
  a_overflow_discard: assert property (p_overflow_discard) else $error("overflow byte not discarded");

  property p_disabled_quiet;
    @(posedge clock) disable iff (sys_rst)
      !en |=> (!sclk_oe_reg && !miso_oe_reg && !mosi_oe_reg);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("pins driven while disabled");

  property p_idle_level;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == SMSP_IDLE) ##1 (state_reg == SMSP_IDLE) |-> (sclk_o_reg == $past(cpol));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("serial clock not at idle level");

endmodule // smsp_port

// >>> testbench/smsp_slave_model.sv
`timescale 1ns/1ps
// ************************************************************
// External serial slave, clock idle low, sample on leading edge
// ************************************************************
module smsp_slave_model (
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  // Bench side
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  initial rx_byte = 8'h00;
  // First bit stands before the first edge, loaded on select
  always @(negedge ss_n) sh = tx_byte;
  // Sample on the rising edge, launch the next bit on the falling one
  always @(posedge sclk) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sclk) if (!ss_n) sh = {sh[6:0], 1'b0};
  // A released line shows the inverse of its last bit, so a stale read is caught
  assign miso = ss_n ? ~sh[7] : sh[7];
endmodule // smsp_slave_model

// >>> testbench/smsp_port_test.sv
`timescale 1ns/1ps
module smsp_port_test;
  import smsp_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata, d;
  logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, miso_w;
  logic [7:0]  s_tx = 8'h00;
  logic [7:0]  s_rx;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  // Released pins fall to their pull levels
  wire sclk_w = sclk_oe ? sclk_o : 1'b0;
  wire ss_w   = ss_n_oe ? ss_n_o : 1'b1;
  initial forever #2.5 clock = ~clock;
  smsp_port dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .mosi_i(1'b0), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(1'b1), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
  smsp_slave_model peer (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_o), .miso(miso_w),
    .tx_byte(s_tx), .rx_byte(s_rx));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge clock); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clock); reg_wr <= 1'b0;
  endtask
  task rd(input logic [31:0] a);
    @(posedge clock); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bounded poll of one status bit
  task wait_stat(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(SMSP_STATUS_ADDR);
      if (d[b] === 1'b1) break;
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset;
    rd(SMSP_STATUS_ADDR);   check("status", d, 16'h0000);
    rd(SMSP_DIVIDER_ADDR);  check("divider", d, 16'h001B);
    rd(SMSP_CONTROL_ADDR);  check("control", d, 16'h0000);
    rd(SMSP_TRANSMIT_ADDR); check("transmit", d, 16'h0000);
    rd(32'hFFFF0A14);       check("unmapped", d, 16'h0000);
    wr(SMSP_CONTROL_ADDR, 16'hFFFF); rd(SMSP_CONTROL_ADDR);
    check("ctl_mask", d, 16'h1FEF);
    check("ss_oe", {15'h0, ss_n_oe}, 16'h0001);
    wr(SMSP_CONTROL_ADDR, 16'h0000); rd(SMSP_CONTROL_ADDR);
    check("sclk_off", {15'h0, sclk_oe}, 16'h0000);
  endtask
  task t_msb;
    wr(SMSP_DIVIDER_ADDR, 16'h0000);
    wr(SMSP_CONTROL_ADDR, 16'h0243);
    s_tx = 8'h3C;
    wr(SMSP_TRANSMIT_ADDR, 16'h00A5);
    rd(SMSP_STATUS_ADDR); check("busy", {15'h0, d[0]}, 16'h0001);
    wait_stat(3);
    check("st_full", d, 16'h001A);
    check("peer_rx", {8'h0, s_rx}, 16'h00A5);
    rd(SMSP_RECEIVE_ADDR); check("rx", d, 16'h003C);
    rd(SMSP_STATUS_ADDR); check("st_read", d, 16'h0002);
  endtask
  task t_ovf;
    s_tx = 8'h22; wr(SMSP_TRANSMIT_ADDR, 16'h0011); wait_stat(3);
    s_tx = 8'h44; wr(SMSP_TRANSMIT_ADDR, 16'h0033); wait_stat(5);
    check("ovf", {15'h0, d[5]}, 16'h0001);
    rd(SMSP_RECEIVE_ADDR); check("discard", d, 16'h0022);
    rd(SMSP_STATUS_ADDR); check("ovf_clr", d, 16'h0002);
  endtask
  task t_lsb;
    wr(SMSP_CONTROL_ADDR, 16'h0263);
    s_tx = 8'h01; wr(SMSP_TRANSMIT_ADDR, 16'h0001); wait_stat(3);
    check("lsb_out", {8'h0, s_rx}, 16'h0080);
    rd(SMSP_RECEIVE_ADDR); check("lsb_in", d, 16'h0080);
  endtask
  // Loopback: the port hears its own output, the peer's data is ignored
  task t_loop;
    wr(SMSP_CONTROL_ADDR, 16'h0A43);
    s_tx = 8'hC3; wr(SMSP_TRANSMIT_ADDR, 16'h005A); wait_stat(3);
    check("loop_peer", {8'h0, s_rx}, 16'h005A);
    check("mosi_oe", {15'h0, mosi_oe}, 16'h0001);
    check("miso_oe", {15'h0, miso_oe}, 16'h0000);
    rd(SMSP_RECEIVE_ADDR); check("loop_rx", d, 16'h005A);
  endtask
  // Receive-read start with an empty transmit register resends the last byte
  task t_under;
    wr(SMSP_CONTROL_ADDR, 16'h0283);
    s_tx = 8'h77; rd(SMSP_RECEIVE_ADDR); wait_stat(3);
    check("udf_stat", d, 16'h001E);
    check("udf_peer", {8'h0, s_rx}, 16'h005A);
    rd(SMSP_RECEIVE_ADDR); check("udf_rx", d, 16'h0077);
  endtask
  // ************************************************************
  // Run and hang guard
  // ************************************************************
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset;
    t_msb;
    t_ovf;
    t_lsb;
    t_loop;
    t_under;
    stop_test;
  end
endmodule // smsp_port_test
